// [design/crb_pkg.sv]
// Shared opcodes, cycle counts, bus offsets and helper functions for the decode core
package crb_pkg;

	// Miscellaneous single-byte opcodes
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_CARRY_CLEAR = 8'h01;
	localparam logic [7:0] OP_CARRY_SET = 8'h02;
	localparam logic [7:0] OP_CARRY_INVERT = 8'h03;
	localparam logic [7:0] OP_IRQ_MASK_ALL = 8'h04;
	localparam logic [7:0] OP_IRQ_UNMASK_ALL = 8'h05;
	localparam logic [7:0] OP_WATCHDOG_KICK = 8'h06;
	// Branch group
	localparam logic [7:0] OP_BRANCH_IF_CARRY = 8'h20;
	localparam logic [7:0] OP_BRANCH_IF_NO_CARRY = 8'h21;
	localparam logic [7:0] OP_BRANCH_IF_ZERO = 8'h22;
	localparam logic [7:0] OP_BRANCH_IF_NONZERO = 8'h23;
	localparam logic [7:0] OP_BRANCH_IF_NEGATIVE = 8'h24;
	localparam logic [7:0] OP_BRANCH_IF_NOT_NEGATIVE = 8'h25;
	localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h26;
	localparam logic [7:0] OP_SUBROUTINE_CALL = 8'h27;
	localparam logic [7:0] OP_SUBROUTINE_EXIT = 8'h28;
	localparam logic [7:0] OP_INTERRUPT_EXIT = 8'h29;
	localparam logic [7:0] OP_BRANCH_VIA_POINTER = 8'h2A;
	// Rotate and shift group
	localparam logic [7:0] OP_ROTATE_LEFT = 8'h30;
	localparam logic [7:0] OP_ROTATE_RIGHT = 8'h31;
	localparam logic [7:0] OP_ROTATE_LEFT_THRU_CARRY = 8'h32;
	localparam logic [7:0] OP_ROTATE_RIGHT_THRU_CARRY = 8'h33;
	localparam logic [7:0] OP_SHIFT_LEFT_ZERO_FILL = 8'h34;
	localparam logic [7:0] OP_SHIFT_RIGHT_ZERO_FILL = 8'h35;
	localparam logic [7:0] OP_SHIFT_RIGHT_SIGN_FILL = 8'h36;
	// Arithmetic and logical group
	localparam logic [7:0] OP_ALU_REG_FIRST = 8'h40;
	localparam logic [7:0] OP_ALU_REG_LAST = 8'h48;
	localparam logic [7:0] OP_STEP_UP = 8'h49;
	localparam logic [7:0] OP_STEP_DOWN = 8'h4A;
	localparam logic [7:0] OP_ALU_IMM_FIRST = 8'h50;
	localparam logic [7:0] OP_ALU_IMM_LAST = 8'h58;
	localparam logic [7:0] OP_PAIR_COMPARE = 8'h66;
	localparam logic [7:0] OP_PAIR_STEP_UP = 8'h69;

	// Function codes held in the low nibble of the two-operand opcodes
	localparam logic [3:0] FN_AND = 4'h0;
	localparam logic [3:0] FN_MASK_TEST = 4'h1;
	localparam logic [3:0] FN_OR = 4'h2;
	localparam logic [3:0] FN_XOR = 4'h3;
	localparam logic [3:0] FN_SUB = 4'h4;
	localparam logic [3:0] FN_COMPARE_ONLY = 4'h5;
	localparam logic [3:0] FN_SUB_BORROW_IN = 4'h6;
	localparam logic [3:0] FN_ADD = 4'h7;
	localparam logic [3:0] FN_ADD_CARRY_IN = 4'h8;

	// Base cycle counts at zero wait states
	localparam logic [3:0] CYC_MISC = 4'h2;
	localparam logic [3:0] CYC_BRANCH = 4'h3;
	localparam logic [3:0] CYC_POINTER = 4'h4;
	localparam logic [3:0] CYC_ROTATE = 4'h5;
	localparam logic [3:0] CYC_ALU_REG = 4'h6;
	localparam logic [3:0] CYC_ALU_IMM = 4'h5;
	localparam logic [3:0] CYC_STEP = 4'h5;
	localparam logic [3:0] CYC_PAIR_STEP = 4'h8;
	localparam logic [3:0] CYC_PAIR_CMP = 4'hA;

	// Instruction lengths in bytes
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// Reset values
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [2:0] RST_WS = 3'h0;
	localparam int STK_DEPTH = 4;

	// Bus offsets and field positions
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam int CTRL_WS_LSB = 0;
	localparam int STAT_CARRY = 0;
	localparam int STAT_ZERO = 1;
	localparam int STAT_SIGN = 2;
	localparam int STAT_IRQ_EN = 3;

	typedef enum logic [1:0] {PH_FETCH, PH_EXEC1, PH_EXEC2, PH_PAD} crb_phase_t;

	// Two-operand forms and single-operand steps
	function automatic logic is_alu(input logic [7:0] op);
		return (op >= OP_ALU_REG_FIRST && op <= OP_STEP_DOWN) ||
			(op >= OP_ALU_IMM_FIRST && op <= OP_ALU_IMM_LAST);
	endfunction

	// Absolute three-byte branches and call
	function automatic logic is_branch(input logic [7:0] op);
		return op >= OP_BRANCH_IF_CARRY && op <= OP_SUBROUTINE_CALL;
	endfunction

	function automatic logic is_rotate(input logic [7:0] op);
		return op >= OP_ROTATE_LEFT && op <= OP_SHIFT_RIGHT_SIGN_FILL;
	endfunction

	// Bytes per opcode; unknown codes behave as one-byte no-ops
	function automatic logic [1:0] op_len(input logic [7:0] op);
		if (is_branch(op) || op == OP_PAIR_COMPARE) begin
			return LEN_THREE;
		end else if (op == OP_STEP_UP || op == OP_STEP_DOWN) begin
			return LEN_TWO;
		end else if (is_alu(op)) begin
			return LEN_THREE;
		end else if (is_rotate(op) || op == OP_BRANCH_VIA_POINTER || op == OP_PAIR_STEP_UP) begin
			return LEN_TWO;
		end
		return LEN_ONE;
	endfunction

	// Work cycles per opcode, wait stalls excluded
	function automatic logic [3:0] op_cycles(input logic [7:0] op);
		if (is_branch(op)) begin
			return CYC_BRANCH;
		end else if (op == OP_BRANCH_VIA_POINTER) begin
			return CYC_POINTER;
		end else if (is_rotate(op)) begin
			return CYC_ROTATE;
		end else if (op == OP_STEP_UP || op == OP_STEP_DOWN) begin
			return CYC_STEP;
		end else if (op >= OP_ALU_REG_FIRST && op <= OP_ALU_REG_LAST) begin
			return CYC_ALU_REG;
		end else if (is_alu(op)) begin
			return CYC_ALU_IMM;
		end else if (op == OP_PAIR_STEP_UP) begin
			return CYC_PAIR_STEP;
		end else if (op == OP_PAIR_COMPARE) begin
			return CYC_PAIR_CMP;
		end
		return CYC_MISC;
	endfunction

endpackage

// [design/crb_regfile.sv]
// Register-space SRAM: two asynchronous read ports, one synchronous write port
`timescale 1ns/1ps
`default_nettype none
module crb_regfile (
	input wire logic sys_clk,
	input wire logic clk_en,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] ra_addr,
	output logic [7:0] ra_data,
	input wire logic [7:0] rb_addr,
	output logic [7:0] rb_data
);
	// No reset: contents are undefined until software writes them
	logic [7:0] mem [0:255];

	// Write port, frozen with the clock enable
	always_ff @(posedge sys_clk) begin
		if (clk_en && we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read ports see the value written at the previous edge
	assign ra_data = mem[ra_addr];
	assign rb_data = mem[rb_addr];
endmodule // crb_regfile
`default_nettype wire

// [design/crb_core.sv]
// Fetch, decode and execute core for rotate, branch, arithmetic and misc opcodes
// Functional notes
// - Rotates touch SRAM, change carry only
// - Rotate left/right, carry from edge bit
// - Nine-bit rotates through carry flag
// - Zero-fill shifts, carry from outgoing bit
// - Arithmetic right shift keeps sign bit
// - Absolute three-byte conditional branches and call
// - Pointer branch reads target from pair
// - Pointer low byte at address plus one
// - ALU first operand from SRAM, second from SRAM or immediate, result written back
// - Mask test and compare write no result
// - Every ALU op sets sign and zero
// - Arithmetic updates carry, logic leaves it
// - Carry high means borrow on subtracts
// - Register form six, immediate five cycles
// - Step up/down single operand, five cycles
// - Pair increment eight, compare ten cycles
// - Wait states stretch only program fetches
`timescale 1ns/1ps
`default_nettype none
module crb_core
	import crb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] pm_addr,
	input wire logic [7:0] pm_rdata,
	output logic irq_enable,
	output logic watchdog_kick
);
	typedef struct packed {
		crb_phase_t phase;
		logic [15:0] pc;
		logic [7:0] op;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] nb;
		logic [3:0] work;
		logic [2:0] wcnt;
		logic [15:0] tmp;
		logic carry;
		logic zero;
		logic sign;
		logic irq_en;
		logic wd_kick;
		logic [STK_DEPTH-1:0][15:0] stk;
		logic [1:0] sp;
		logic [2:0] ws;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} crb_state_t;

	localparam crb_state_t RST_STATE = '{phase: PH_FETCH, pc: RST_PC, ws: RST_WS, default: '0};

	crb_state_t st_ff;
	crb_state_t nxt_st;
	logic [7:0] ra_addr;
	logic [7:0] rb_addr;
	logic [7:0] rda;
	logic [7:0] rdb;
	logic rf_we;
	logic [7:0] rf_waddr;
	logic [7:0] rf_wdata;
	logic [7:0] cur_op;
	logic [3:0] fn;
	logic [7:0] bval;
	logic [8:0] res9;
	logic [16:0] res17;
	logic finish;
	logic taken;

	// Two-operand result as {carry or borrow, byte}
	function automatic logic [8:0] alu_calc(input logic [3:0] f, input logic [7:0] a,
			input logic [7:0] b, input logic cin);
		logic [8:0] r;
		r = {cin, a & b};
		case (f)
			FN_OR: r = {cin, a | b};
			FN_XOR: r = {cin, a ^ b};
			FN_SUB, FN_COMPARE_ONLY: r = {1'b0, a} - {1'b0, b};
			FN_SUB_BORROW_IN: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			FN_ADD: r = {1'b0, a} + {1'b0, b};
			FN_ADD_CARRY_IN: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			default: r = {cin, a & b};
		endcase
		return r;
	endfunction

	// Rotate and shift result as {carry, byte}
	function automatic logic [8:0] rot_calc(input logic [7:0] op, input logic [7:0] a,
			input logic cin);
		logic [8:0] r;
		r = {cin, a};
		case (op)
			OP_ROTATE_LEFT: r = {a[7], a[6:0], a[7]};
			OP_ROTATE_RIGHT: r = {a[0], a[0], a[7:1]};
			OP_ROTATE_LEFT_THRU_CARRY: r = {a[7], a[6:0], cin};
			OP_ROTATE_RIGHT_THRU_CARRY: r = {a[0], cin, a[7:1]};
			OP_SHIFT_LEFT_ZERO_FILL: r = {a[7], a[6:0], 1'b0};
			OP_SHIFT_RIGHT_ZERO_FILL: r = {a[0], 1'b0, a[7:1]};
			OP_SHIFT_RIGHT_SIGN_FILL: r = {a[0], a[7], a[7:1]};
			default: r = {cin, a};
		endcase
		return r;
	endfunction

	crb_regfile u_regfile (
		.sys_clk(sys_clk),
		.clk_en(clk_en),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata),
		.ra_addr(ra_addr),
		.ra_data(rda),
		.rb_addr(rb_addr),
		.rb_data(rdb)
	);

	// Next-state logic for the sequencer and the bus slave
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wd_kick = 1'b0;
		ra_addr = st_ff.b1;
		rb_addr = st_ff.b2;
		rf_we = 1'b0;
		rf_waddr = st_ff.b1;
		rf_wdata = 8'h00;
		cur_op = st_ff.op;
		fn = st_ff.op[3:0];
		bval = st_ff.op[4] ? st_ff.b2 : rdb;
		res9 = '0;
		res17 = '0;
		finish = 1'b0;
		taken = 1'b0;
		case (st_ff.phase)
			PH_FETCH: begin
				if (st_ff.wcnt != st_ff.ws) begin
					nxt_st.wcnt = st_ff.wcnt + 3'd1;
				end else begin
					nxt_st.wcnt = 3'd0;
					nxt_st.pc = st_ff.pc + 16'd1;
					if (st_ff.nb == 2'd0) begin
						cur_op = pm_rdata;
						nxt_st.op = pm_rdata;
					end else if (st_ff.nb == 2'd1) begin
						nxt_st.b1 = pm_rdata;
					end else begin
						nxt_st.b2 = pm_rdata;
					end
					if (st_ff.nb + 2'd1 == op_len(cur_op)) begin
						nxt_st.nb = 2'd0;
						if (is_branch(cur_op)) begin
							case (cur_op)
								OP_BRANCH_IF_CARRY: taken = st_ff.carry;
								OP_BRANCH_IF_NO_CARRY: taken = !st_ff.carry;
								OP_BRANCH_IF_ZERO: taken = st_ff.zero;
								OP_BRANCH_IF_NONZERO: taken = !st_ff.zero;
								OP_BRANCH_IF_NEGATIVE: taken = st_ff.sign;
								OP_BRANCH_IF_NOT_NEGATIVE: taken = !st_ff.sign;
								default: taken = 1'b1;
							endcase
							if (cur_op == OP_SUBROUTINE_CALL) begin
								nxt_st.stk[st_ff.sp] = st_ff.pc + 16'd1;
								nxt_st.sp = st_ff.sp + 2'd1;
							end
							if (taken) begin
								nxt_st.pc = {pm_rdata, st_ff.b1};
							end
							finish = 1'b1;
						end else begin
							nxt_st.phase = PH_EXEC1;
							nxt_st.work = st_ff.work + 4'd1;
						end
					end else begin
						nxt_st.nb = st_ff.nb + 2'd1;
						nxt_st.work = st_ff.work + 4'd1;
					end
				end
			end
			PH_EXEC1: begin
				finish = 1'b1;
				if (is_rotate(st_ff.op)) begin
					res9 = rot_calc(st_ff.op, rda, st_ff.carry);
					rf_we = 1'b1;
					rf_wdata = res9[7:0];
					nxt_st.carry = res9[8];
				end else if (is_alu(st_ff.op)) begin
					if (st_ff.op == OP_STEP_UP || st_ff.op == OP_STEP_DOWN) begin
						fn = (st_ff.op == OP_STEP_UP) ? FN_ADD : FN_SUB;
						bval = 8'h01;
					end
					res9 = alu_calc(fn, rda, bval, st_ff.carry);
					// no write for test and compare
					rf_we = (fn != FN_MASK_TEST) && (fn != FN_COMPARE_ONLY);
					rf_wdata = res9[7:0];
					nxt_st.zero = (res9[7:0] == 8'h00);
					nxt_st.sign = res9[7];
					// carry or borrow on arithmetic only
					if (fn >= FN_SUB) begin
						nxt_st.carry = res9[8];
					end
				end else if (st_ff.op == OP_BRANCH_VIA_POINTER) begin
					// low byte at pointer plus one
					ra_addr = st_ff.b1 + 8'd1;
					rb_addr = st_ff.b1;
					nxt_st.pc = {rdb, rda};
				end else if (st_ff.op == OP_PAIR_STEP_UP || st_ff.op == OP_PAIR_COMPARE) begin
					rb_addr = st_ff.b1 + 8'd1;
					res17 = {1'b0, rdb, rda} + 17'd1;
					rf_we = (st_ff.op == OP_PAIR_STEP_UP);
					rf_wdata = res17[7:0];
					nxt_st.tmp = (st_ff.op == OP_PAIR_STEP_UP) ? res17[15:0] : {rdb, rda};
					nxt_st.phase = PH_EXEC2;
					nxt_st.work = st_ff.work + 4'd1;
					finish = 1'b0;
				end else if (st_ff.op == OP_SUBROUTINE_EXIT || st_ff.op == OP_INTERRUPT_EXIT) begin
					nxt_st.pc = st_ff.stk[st_ff.sp - 2'd1];
					nxt_st.sp = st_ff.sp - 2'd1;
					if (st_ff.op == OP_INTERRUPT_EXIT) begin
						nxt_st.irq_en = 1'b1;
					end
				end else begin
					case (st_ff.op)
						OP_CARRY_CLEAR: nxt_st.carry = 1'b0;
						OP_CARRY_SET: nxt_st.carry = 1'b1;
						OP_CARRY_INVERT: nxt_st.carry = !st_ff.carry;
						OP_IRQ_MASK_ALL: nxt_st.irq_en = 1'b0;
						OP_IRQ_UNMASK_ALL: nxt_st.irq_en = 1'b1;
						OP_WATCHDOG_KICK: nxt_st.wd_kick = 1'b1;
						default: nxt_st.wd_kick = 1'b0;
					endcase
				end
			end
			PH_EXEC2: begin
				finish = 1'b1;
				if (st_ff.op == OP_PAIR_STEP_UP) begin
					// high byte of the incremented pair
					rf_we = 1'b1;
					rf_waddr = st_ff.b1 + 8'd1;
					rf_wdata = st_ff.tmp[15:8];
				end else begin
					ra_addr = st_ff.b2;
					rb_addr = st_ff.b2 + 8'd1;
					res17 = {1'b0, st_ff.tmp} - {1'b0, rdb, rda};
					nxt_st.carry = res17[16];
					nxt_st.zero = (res17[15:0] == 16'h0000);
					nxt_st.sign = res17[15];
				end
			end
			default: begin
				finish = 1'b1;
			end
		endcase
		// pad to the base cycle count
		if (finish) begin
			if (st_ff.work == op_cycles(cur_op) - 4'd1) begin
				nxt_st.phase = PH_FETCH;
				nxt_st.work = 4'd0;
			end else begin
				nxt_st.phase = PH_PAD;
				nxt_st.work = st_ff.work + 4'd1;
			end
		end
		// Bus slave: answer in the access cycle after setup
		nxt_st.pready = 1'b0;
		nxt_st.pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_st.pready = 1'b1;
			nxt_st.prdata = 32'h0000_0000;
			if (paddr == ADDR_CTRL) begin
				nxt_st.prdata[CTRL_WS_LSB +: 3] = st_ff.ws;
			end else if (paddr == ADDR_STATUS) begin
				nxt_st.prdata[STAT_CARRY] = st_ff.carry;
				nxt_st.prdata[STAT_ZERO] = st_ff.zero;
				nxt_st.prdata[STAT_SIGN] = st_ff.sign;
				nxt_st.prdata[STAT_IRQ_EN] = st_ff.irq_en;
			end else if (paddr == ADDR_PC) begin
				nxt_st.prdata[15:0] = st_ff.pc;
			end else begin
				nxt_st.pslverr = 1'b1;
			end
		end
		// Wait-state count changes take effect at the next fetch stall check
		if (psel && penable && st_ff.pready && pwrite && paddr == ADDR_CTRL) begin
			nxt_st.ws = pwdata[CTRL_WS_LSB +: 3];
		end
	end

	// State register, frozen while the clock enable is low unless reset is high
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_ff <= RST_STATE;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign pm_addr = st_ff.pc;
	assign irq_enable = st_ff.irq_en;
	assign watchdog_kick = st_ff.wd_kick;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_rot_keeps_sz;
		clk_en && st_ff.phase == PH_EXEC1 && is_rotate(st_ff.op) |=> $stable(st_ff.zero) && $stable(st_ff.sign);
	endproperty
	a_rot_keeps_sz: assert property (p_rot_keeps_sz) else $error("rotate changed sign or zero");

	property p_rl_carry;
		clk_en && st_ff.phase == PH_EXEC1 && st_ff.op == OP_ROTATE_LEFT |=> st_ff.carry == $past(rda[7]);
	endproperty
	a_rl_carry: assert property (p_rl_carry) else $error("rotate left carry wrong");

	property p_rlc_data;
		st_ff.phase == PH_EXEC1 && st_ff.op == OP_ROTATE_LEFT_THRU_CARRY |-> rf_we && rf_wdata == {rda[6:0], st_ff.carry};
	endproperty
	a_rlc_data: assert property (p_rlc_data) else $error("rotate through carry wrong");

	property p_shl_fill;
		st_ff.phase == PH_EXEC1 && st_ff.op == OP_SHIFT_LEFT_ZERO_FILL |-> rf_we && !rf_wdata[0];
	endproperty
	a_shl_fill: assert property (p_shl_fill) else $error("shift left did not clear bit 0");

	property p_sar_sign;
		st_ff.phase == PH_EXEC1 && st_ff.op == OP_SHIFT_RIGHT_SIGN_FILL |-> rf_wdata[7] == rda[7] && rf_wdata[6] == rda[7];
	endproperty
	a_sar_sign: assert property (p_sar_sign) else $error("arithmetic shift lost sign");

	property p_jmp_target;
		clk_en && st_ff.phase == PH_FETCH && st_ff.nb == 2'd2 && st_ff.wcnt == st_ff.ws && st_ff.op == OP_BRANCH_ALWAYS
			|=> st_ff.pc == {$past(pm_rdata), $past(st_ff.b1)} && st_ff.phase == PH_FETCH;
	endproperty
	a_jmp_target: assert property (p_jmp_target) else $error("absolute branch target wrong");

	property p_ptr_order;
		clk_en && st_ff.phase == PH_EXEC1 && st_ff.op == OP_BRANCH_VIA_POINTER
			|-> ra_addr == st_ff.b1 + 8'd1 ##1 st_ff.pc == {$past(rdb), $past(rda)};
	endproperty
	a_ptr_order: assert property (p_ptr_order) else $error("pointer branch byte order wrong");

	property p_test_no_write;
		st_ff.phase == PH_EXEC1 && is_alu(st_ff.op) && (st_ff.op[3:0] == FN_MASK_TEST || st_ff.op[3:0] == FN_COMPARE_ONLY)
			&& st_ff.op != OP_STEP_UP |-> !rf_we;
	endproperty
	a_test_no_write: assert property (p_test_no_write) else $error("test or compare wrote result");

	property p_logic_carry;
		clk_en && st_ff.phase == PH_EXEC1 && is_alu(st_ff.op) && st_ff.op[3:0] < FN_SUB |=> $stable(st_ff.carry);
	endproperty
	a_logic_carry: assert property (p_logic_carry) else $error("logic op changed carry");

	property p_sub_borrow;
		clk_en && st_ff.phase == PH_EXEC1 && st_ff.op == 8'h44 && rda < rdb |=> st_ff.carry;
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow did not set carry");

	property p_misc_two;
		clk_en && st_ff.phase == PH_EXEC1 && st_ff.op == OP_CARRY_CLEAR |=> !st_ff.carry && st_ff.phase == PH_FETCH;
	endproperty
	a_misc_two: assert property (p_misc_two) else $error("carry clear timing wrong");
endmodule // crb_core
`default_nettype wire

// [dv/crb_rom_model.sv]
// Program memory model: asynchronous byte store answering the core's fetch address
`timescale 1ns/1ps
`default_nettype none
module crb_rom_model (
	input wire logic [15:0] pm_addr,
	output logic [7:0] pm_rdata
);
	logic [7:0] mem [256];

	// Combinational read; outside the image a changing filler, so a stray fetch never looks clean
	always_comb begin
		if (pm_addr[15:8] == 8'h00) begin
			pm_rdata = mem[pm_addr[7:0]];
		end else begin
			pm_rdata = ~pm_addr[7:0];
		end
	end
endmodule // crb_rom_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the decode core running a program image
`timescale 1ns/1ps
`default_nettype none
module testbench
	import crb_pkg::*;
	;
	logic sys_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, slv;
	logic irq_enable, watchdog_kick;
	logic [7:0] paddr, pm_rdata;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pm_addr;
	int errors, checks, cyc, kicks, pc_at, n_ins;
	int seen [256];
	int i_adr [80], i_nxt [80], i_len [80], i_cyc [80];

	crb_core i_crb_core (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .irq_enable(irq_enable), .watchdog_kick(watchdog_kick));
	crb_rom_model i_crb_rom_model (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// First arrival of each fetch address, kick pulses, hang cutoff
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (!rst && pm_addr[15:8] == 8'h00 && seen[pm_addr[7:0]] == 0) begin
			seen[pm_addr[7:0]] <= cyc;
		end
		if (watchdog_kick === 1'b1) begin
			kicks <= kicks + 1;
		end
		if (cyc == 20000) begin
			errors = errors + 1;
			close_out();
		end
	end

	task automatic close_out();
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; pready, data and error are taken at the rising edge that completes it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) errors++;
	endtask

	task automatic reset_core();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	task automatic raw(input logic [23:0] w);
		i_crb_rom_model.mem[pc_at] = w[23:16];
		i_crb_rom_model.mem[pc_at + 1] = w[15:8];
		i_crb_rom_model.mem[pc_at + 2] = w[7:0];
	endtask

	// Place one instruction and note where the next fetch must start and when
	task automatic ins(input logic [23:0] w, input int len, input int base, input int nxt = 0);
		i_adr[n_ins] = pc_at;
		i_len[n_ins] = len;
		i_cyc[n_ins] = base;
		i_nxt[n_ins] = (nxt == 0) ? pc_at + len : nxt;
		raw(w);
		pc_at = pc_at + len;
		n_ins++;
	endtask

	// Guard branch to the trap address; taken only when a flag is wrong
	task automatic bad(input logic [7:0] op);
		ins({op, 16'hF000}, 3, 3);
	endtask

	task automatic build();
		pc_at = 16'h0010;
		n_ins = 0;
		ins(24'h50_2000, 3, 5);
		ins(24'h52_2081, 3, 5);
		ins(24'h30_2000, 2, 5); // rotate left
		ins(24'h33_2000, 2, 5); // nine-bit right
		ins(24'h36_2000, 2, 5); // sign fill
		ins(24'h35_2000, 2, 5); // zero fill
		ins(24'h55_2060, 3, 5);
		bad(8'h23);
		ins(24'h34_2000, 2, 5); // zero fill
		ins(24'h32_2000, 2, 5); // nine-bit left
		ins(24'h31_2000, 2, 5); // rotate right
		ins(24'h55_2040, 3, 5);
		bad(8'h23);
		ins(24'h50_2100, 3, 5);
		ins(24'h52_2105, 3, 5);
		ins(24'h44_2021, 3, 6); // register form
		ins(24'h54_203C, 3, 5); // borrow high
		bad(8'h21);
		ins(24'h49_2000, 2, 5); // step up
		bad(8'h23);
		ins(24'h4A_2000, 2, 5); // step down borrow
		bad(8'h25);
		bad(8'h21);
		ins(24'h41_2021, 3, 6); // carry kept
		bad(8'h21);
		bad(8'h22);
		ins(24'h55_20FF, 3, 5); // destination untouched
		bad(8'h23);
		bad(8'h20);
		ins(24'h03_0000, 1, 2);
		bad(8'h21);
		ins(24'h01_0000, 1, 2);
		bad(8'h20);
		ins(24'h02_0000, 1, 2);
		bad(8'h21);
		ins(24'h58_2110, 3, 5);
		ins(24'h55_2116, 3, 5);
		bad(8'h23);
		ins(24'h57_21EA, 3, 5);
		bad(8'h23);
		bad(8'h21);
		ins(24'h53_21FF, 3, 5);
		bad(8'h21);
		ins(24'h56_21FE, 3, 5);
		bad(8'h23);
		bad(8'h20);
		ins(24'h04_0000, 1, 2);
		ins(24'h05_0000, 1, 2);
		ins(24'h06_0000, 1, 2);
		ins(24'h50_2200, 3, 5);
		ins(24'h52_22FF, 3, 5);
		ins(24'h50_2300, 3, 5);
		ins(24'h69_2200, 2, 8); // carry into high byte
		ins(24'h55_2301, 3, 5);
		bad(8'h23);
		ins(24'h50_2400, 3, 5);
		ins(24'h50_2500, 3, 5);
		ins(24'h52_25C0, 3, 5);
		ins(24'h2A_2400, 2, 4, 16'h00C0); // low byte second
		raw(24'h26_F000);
		pc_at = 16'h00C0;
		ins(24'h66_2224, 3, 10);
		ins(24'h27_D000, 3, 3, 16'h00D0);
		raw(24'h26_C600);
		pc_at = 16'h00D0;
		ins(24'h28_0000, 1, 2, 16'h00C6); // return address
	endtask

	// Reset values, read-only status, unmapped access
	task automatic regs();
		reset_core();
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		cmp("ctrl reset", 32'h0000_0000, rd);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		cmp("status reset", 32'h0000_0000, rd);
		apb(1'b1, ADDR_CTRL, 32'h0000_0005);
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		cmp("ctrl", 32'h0000_0005, rd);
		apb(1'b1, ADDR_STATUS, 32'h0000_000F);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		cmp("status", 32'h0000_0000, rd);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		cmp("unmapped err", 32'h0000_0001, 32'(slv));
		cmp("unmapped data", 32'h0000_0000, rd);
	endtask

	// Run the image at a given wait-state setting; released by patching the idle loop
	task automatic run(input int ws);
		int n;
		n = 0;
		i_crb_rom_model.mem[1] = 8'h00;
		kicks = 0;
		reset_core();
		// Cleared after reset, so the previous run's loop cannot satisfy this one
		for (int k = 0; k < 256; k++) begin
			seen[k] = 0;
		end
		apb(1'b1, ADDR_CTRL, ws);
		i_crb_rom_model.mem[1] = 8'h10;
		// Address after the final loop head, so every end point below is recorded
		while (seen[8'hC7] == 0 && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		cmp("flags", 32'h0000_0009, rd); // pair borrow
		cmp("irq enable", 32'h0000_0001, 32'(irq_enable)); // unmask
		cmp("kicks", 1, kicks); // one pulse
		cmp("trap", 0, seen[8'hF0]); // Guards
		cmp("end", 1, seen[8'hC6] != 0); // Path
		// The counter steps past the opcode byte once it is taken, so opcode+1 marks each start
		for (int i = 0; i < n_ins; i++) begin
			cmp("cycles", i_cyc[i] + ws * i_len[i], seen[i_nxt[i] + 1] - seen[i_adr[i] + 1]);
		end
		// Clock enable low must hold the fetch address still
		clk_en <= 1'b0;
		@(posedge sys_clk);
		pc_at = pm_addr;
		repeat (5) @(posedge sys_clk);
		cmp("freeze", pc_at, pm_addr);
		clk_en <= 1'b1;
	endtask

	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		errors = 0;
		checks = 0;
		cyc = 1;
		kicks = 0;
		for (int k = 0; k < 256; k++) begin
			i_crb_rom_model.mem[k] = 8'h00;
		end
		i_crb_rom_model.mem[0] = 8'h26;
		build();
		regs();
		run(0);
		run(2);
		close_out();
	end
endmodule // testbench
`default_nettype wire
